// >>> tb/cache_sram_control_bench.sv
// Purpose: Self-checking bench for the cache SRAM control block.
// Assumes: Memory model returns each word's own address as data.
// Notes: Scenarios share one access task that tallies port activity.
`timescale 1ns/1ns
module cache_sram_control_bench;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic cache_enable = 1'b1;
  logic fast_timing = 1'b1;
  logic private_hit_level = 1'b0;
  logic lb_req_valid = 1'b0;
  logic slow = 1'b0;
  logic bad = 1'b0;
  logic sb_snoop_valid = 1'b0;
  logic sb_snoop_foreign = 1'b0;
  logic sb_snoop_noncache = 1'b0;
  logic [31:0] sb_snoop_addr = '0;
  cache_pkg::lb_req_s lb_req = '0;
  cache_pkg::sb_req_s sb_req;
  cache_pkg::sram_pins_s sram_pin_out;
  cache_pkg::sram_pins_s sram_pin_oe;
  logic lb_ready, bad_access_flag, busy, lb_fill_drive, sb_req_valid, sb_req_ready;
  logic sb_fill_valid, sb_fill_bad, sb_fill_ready, way_seen;
  logic [31:0] lb_fill_data, sb_fill_data;
  // Outside byte-lane latch, active low: 0 lets that byte be written
  logic [3:0] be_lat = 4'hf;
  int mismatches = 0;
  int n_compared = 0;
  int n_cyc, n_rdy, n_rd, n_wr, n_fill, n_fetch, n_wt, n_bad;

  always #4 core_clk = ~core_clk;

  cache_sram_control u_cache_sram_control (.core_clk, .rst_n, .cache_enable, .fast_timing,
    .private_hit_level, .lb_req_valid, .lb_req, .lb_ready, .bad_access_flag, .busy,
    .lb_fill_data, .lb_fill_drive, .sb_req_valid, .sb_req, .sb_req_ready, .sb_fill_valid,
    .sb_fill_data, .sb_fill_bad, .sb_fill_ready, .sb_snoop_valid, .sb_snoop_addr,
    .sb_snoop_foreign, .sb_snoop_noncache, .sram_pin_in('0), .sram_pin_out, .sram_pin_oe);
  sys_mem_model u_sys_mem_model (.core_clk, .rst_n, .slow, .bad, .sb_req_valid, .sb_req,
    .sb_req_ready, .sb_fill_valid, .sb_fill_data, .sb_fill_bad, .sb_fill_ready);

  // ==========
  // Helpers
  task automatic close_out;
    if (mismatches == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : close_out

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic tally(input logic [31:0] a);
    logic [3:0] cs;
    n_cyc++;
    if (lb_ready === 1'b1) be_lat = lb_req.write ? 4'h0 : 4'hf;
    if ((lb_req_valid & ~lb_req.write) === 1'b1) be_lat = 4'h0;
    cs = sram_pin_oe.rd_strobe ? 4'hf : (sram_pin_oe.wr_strobe ? ~be_lat : 4'h0);
    if (lb_ready === 1'b1) n_rdy++;
    if (sram_pin_oe.rd_strobe === 1'b1) n_rd++;
    if (sram_pin_oe.wr_strobe === 1'b1) n_wr++;
    if ((sram_pin_oe.rd_strobe | sram_pin_oe.wr_strobe) === 1'b1) way_seen = sram_pin_oe.way_hit;
    if (bad_access_flag === 1'b1) n_bad++;
    if ((sb_req_valid & sb_req_ready & sb_req.write) === 1'b1) n_wt++;
    if ((sb_req_valid & sb_req_ready & ~sb_req.write) === 1'b1) n_fetch++;
    if (lb_fill_drive === 1'b1) begin
      chk("fill word select", {30'h0, ~n_fill[1:0]}, {30'h0, sram_pin_oe.word});
      chk("fill chip selects", 32'hf, {28'h0, cs});
      chk("fill data", {a[31:4], 4'h0} + n_fill * 4, lb_fill_data);
      n_fill++;
    end
  endtask : tally

  // Enters and leaves 1 ns after an edge, with the block idle
  task automatic access(input logic [31:0] a, input logic wr, input logic cach,
                        input logic [1:0] wm1);
    int k;
    {n_cyc, n_rdy, n_rd, n_wr, n_fill, n_fetch, n_wt, n_bad} = '0;
    way_seen = 1'bx;
    @(posedge core_clk);
    lb_req_valid <= 1'b1;
    lb_req <= '{addr: a, write: wr, cacheable: cach, words_m1: wm1};
    #1;
    tally(a);
    @(posedge core_clk);
    lb_req_valid <= 1'b0;
    #1;
    for (k = 0; k < 300 && busy === 1'b1; k++) begin
      tally(a);
      @(posedge core_clk);
      #1;
    end
    if (k == 300) chk("access completion", 0, 1);
  endtask : access

  task automatic expect_counts(input int fetch, input int fill, input int rdy, input int rd,
                               input int bd);
    chk("line fetches", fetch, n_fetch);
    chk("fill writes", fill, n_fill);
    chk("ready cycles", rdy, n_rdy);
    chk("read strobe cycles", rd, n_rd);
    chk("bad flags", bd, n_bad);
  endtask : expect_counts

  task automatic snoop(input logic [31:0] a, input logic foreign, input logic nc);
    @(posedge core_clk);
    sb_snoop_valid <= 1'b1;
    sb_snoop_addr <= a;
    sb_snoop_foreign <= foreign;
    sb_snoop_noncache <= nc;
    @(posedge core_clk);
    sb_snoop_valid <= 1'b0;
    #1;
  endtask : snoop

  // ==========
  // Scenarios
  // Fill buffer seen through the block; word order is judged in tally
  task automatic t_fifo;
    access(32'h0000_a010, 1'b0, 1'b1, 2'h0);
    chk("fifo words passed", 4, n_fill);
    chk("fifo ready when empty", 1, {31'h0, sb_fill_ready});
    chk("fifo drained", 0, {31'h0, lb_fill_drive});
    chk("pin out level", 0, {26'h0, sram_pin_out});
  endtask : t_fifo

  task automatic t_miss_fill;
    access(32'h0000_1238, 1'b0, 1'b1, 2'h0);
    expect_counts(1, 4, 3, 1, 0);
  endtask : t_miss_fill

  task automatic t_hit_timing;
    int i;
    int w;
    for (i = 0; i < 4; i++) begin
      fast_timing <= i[0];
      private_hit_level <= i[1];
      w = i[1] ? 4 : 1;
      access(32'h0000_1230, 1'b0, 1'b1, {i[1], i[1]});
      expect_counts(0, 0, w + 2, i[0] ? w : 2 * w, 0);
      chk("access cycles", (i[0] ? w : 2 * w) + 2, n_cyc);
    end
  endtask : t_hit_timing

  task automatic t_write;
    access(32'h0000_1234, 1'b1, 1'b1, 2'h0);
    chk("write-through requests", 1, n_wt);
    chk("write strobe cycles", 1, n_wr);
    chk("write ready cycles", 3, n_rdy);
    access(32'h0009_0000, 1'b1, 1'b1, 2'h0);
    chk("write miss activity", 0, n_rdy + n_wr + n_wt);
  endtask : t_write

  task automatic t_invalidate;
    access(32'h0000_1234, 1'b1, 1'b0, 2'h0);
    chk("uncached ready cycles", 0, n_rdy);
    access(32'h0000_1230, 1'b0, 1'b1, 2'h0);
    chk("fetch after uncached write", 1, n_fetch);
    snoop(32'h0000_123c, 1'b1, 1'b0);
    access(32'h0000_1230, 1'b0, 1'b1, 2'h0);
    chk("fetch after foreign write", 1, n_fetch);
    snoop(32'h0000_1230, 1'b0, 1'b1);
    access(32'h0000_1230, 1'b0, 1'b1, 2'h0);
    chk("fetch after own uncached write", 1, n_fetch);
    snoop(32'h0000_1230, 1'b0, 1'b0);
    access(32'h0000_1230, 1'b0, 1'b1, 2'h0);
    chk("fetch after own cached write", 0, n_fetch);
  endtask : t_invalidate

  task automatic t_bad_fill;
    slow <= 1'b1;
    bad <= 1'b1;
    access(32'h0000_2000, 1'b0, 1'b1, 2'h0);
    expect_counts(1, 4, 3, 1, 1);
    bad <= 1'b0;
    access(32'h0000_1230, 1'b0, 1'b1, 2'h0);
    chk("fetch after directory flush", 1, n_fetch);
    slow <= 1'b0;
  endtask : t_bad_fill

  task automatic t_replace;
    cache_enable <= 1'b0;
    access(32'h0000_1230, 1'b0, 1'b1, 2'h0);
    chk("disabled activity", 0, n_rdy + n_fetch);
    cache_enable <= 1'b1;
    access(32'h0000_4000, 1'b0, 1'b1, 2'h0);
    chk("first refill way", 1, {31'h0, way_seen});
    access(32'h0000_6000, 1'b0, 1'b1, 2'h0);
    chk("second refill way", 0, {31'h0, way_seen});
    access(32'h0000_4000, 1'b0, 1'b1, 2'h0);
    chk("hit way", 1, {31'h0, way_seen});
    chk("hit fetches", 0, n_fetch);
  endtask : t_replace

  // ==========
  // Sequence
  initial begin
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    #1;
    t_fifo();
    t_miss_fill();
    t_hit_timing();
    t_write();
    t_invalidate();
    t_bad_fill();
    t_replace();
    close_out();
  end

  // Whole run is a few hundred cycles; this leaves wide margin
  initial begin
    #200000;
    mismatches++;
    close_out();
  end
endmodule : cache_sram_control_bench

// >>> tb/cache_sram_control_properties.sv
// Purpose: Port-level checks for the cache SRAM control block.
// Assumes: Strobe oe high means the strobe pin is pulled low.
// Notes: Bound onto every instance of the block.
`timescale 1ns/1ns
module cache_sram_control_properties (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic cache_enable,
  input wire logic fast_timing,
  input wire logic private_hit_level,
  input wire logic lb_req_valid,
  input wire cache_pkg::lb_req_s lb_req,
  input wire logic lb_ready,
  input wire logic bad_access_flag,
  input wire logic busy,
  input wire logic lb_fill_drive,
  input wire logic sb_req_valid,
  input wire cache_pkg::sb_req_s sb_req,
  input wire cache_pkg::sram_pins_s sram_pin_oe
);
  // ==========
  // Properties
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic take;
  logic rd;
  logic wr;
  assign take = lb_req_valid && !busy && cache_enable && lb_req.cacheable;
  assign rd = sram_pin_oe.rd_strobe;
  assign wr = sram_pin_oe.wr_strobe;
  // Strobe at c1 tells a hit from a miss
  sequence s_fast_hit;
    take && !lb_req.write && fast_timing && lb_req.words_m1 == 2'h0 ##1 rd;
  endsequence
  property p_fast_hit; s_fast_hit |-> lb_ready ##1 (lb_ready && !rd) ##1 !lb_ready; endproperty
  a_fast_hit: assert property (p_fast_hit) else $error("fast hit timing wrong");
  property p_ready_addr; take && !lb_req.write |-> lb_ready; endproperty
  a_ready_addr: assert property (p_ready_addr) else $error("no address ready");
  property p_noncache; lb_req_valid && !busy && !lb_req.cacheable |-> !lb_ready ##1 !(rd || wr);
  endproperty
  a_noncache: assert property (p_noncache) else $error("uncached access used cache");
  property p_fill_req;
    sb_req_valid && !sb_req.write |-> sb_req.addr[3:0] == 4'h0 && sb_req.len_bytes == 5'h10 && !rd;
  endproperty
  a_fill_req: assert property (p_fill_req) else $error("bad fetch request");
  property p_fill_strobe; lb_fill_drive |-> wr && !rd; endproperty
  a_fill_strobe: assert property (p_fill_strobe) else $error("fill without write");
  property p_way_stable; (rd || wr) && $past(rd || wr) |-> $stable(sram_pin_oe.way_hit); endproperty
  a_way_stable: assert property (p_way_stable) else $error("way moved in access");
  property p_private; (rd || wr) |-> sram_pin_oe.private_sel == !private_hit_level; endproperty
  a_private: assert property (p_private) else $error("private select level wrong");
  property p_word_early; take && !lb_req.write |-> sram_pin_oe.word == ~lb_req.addr[3:2]; endproperty
  a_word_early: assert property (p_word_early) else $error("word select late");
  property p_write_through; take && lb_req.write && lb_ready |=> sb_req_valid && sb_req.write;
  endproperty
  a_write_through: assert property (p_write_through) else $error("no write-through");
  property p_bad; bad_access_flag |-> lb_ready && rd; endproperty
  a_bad: assert property (p_bad) else $error("bad flag off transfer");
endmodule : cache_sram_control_properties

bind cache_sram_control cache_sram_control_properties u_props (.core_clk, .rst_n, .cache_enable,
  .fast_timing, .private_hit_level, .lb_req_valid, .lb_req, .lb_ready, .bad_access_flag, .busy,
  .lb_fill_drive, .sb_req_valid, .sb_req, .sram_pin_oe);

// >>> tb/sys_mem_model.sv
// Purpose: System memory answering line fetches and write-throughs.
// Assumes: Each fill word carries its own byte address as data.
// Notes: slow adds request latency and a gap after every fill word.
`timescale 1ns/1ns
module sys_mem_model (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic slow,
  input wire logic bad,
  input wire logic sb_req_valid,
  input wire cache_pkg::sb_req_s sb_req,
  output logic sb_req_ready,
  output logic sb_fill_valid,
  output logic [31:0] sb_fill_data,
  output logic sb_fill_bad,
  input wire logic sb_fill_ready
);
  // ==========
  // Responder
  logic [31:0] base_r;
  logic [2:0] left_r;
  logic [1:0] wait_r;
  logic [31:0] word;
  assign word = base_r + {27'h0, 3'h4 - left_r, 2'h0};
  // Released lines show the inverse so stale data never looks valid
  assign sb_fill_data = sb_fill_valid ? word : ~word;
  assign sb_fill_bad = sb_fill_valid ? bad : !bad;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sb_req_ready <= 1'b0;
      sb_fill_valid <= 1'b0;
      left_r <= 3'h0;
      wait_r <= 2'h0;
      base_r <= '0;
    end else begin
      sb_req_ready <= 1'b0;
      if (sb_req_valid && !sb_req_ready && left_r == 3'h0) begin
        wait_r <= wait_r + 2'h1;
        if (wait_r >= (slow ? 2'h2 : 2'h0)) begin
          sb_req_ready <= 1'b1;
          wait_r <= 2'h0;
          if (!sb_req.write) begin
            base_r <= sb_req.addr;
            left_r <= 3'h4;
          end
        end
      end
      if (sb_fill_valid && sb_fill_ready) begin
        left_r <= left_r - 3'h1;
        sb_fill_valid <= !slow && left_r > 3'h1;
      end else if (left_r != 3'h0 && !sb_req_ready) begin
        sb_fill_valid <= 1'b1;
      end
    end
  end
endmodule : sys_mem_model

// >>> verilog/cache_pkg.sv
// Purpose: Shared constants and carriers for the cache SRAM control block.
// Assumes: One 125 MHz core clock, 32-bit addresses and data.
// Notes: Open-drain pin bits mean "pull the pin low" when set.
// What this block does
// - Non-cacheable local write hit invalidates its line
// - Write hit also issues system bus write
// - Read strobe asserted while SRAMs drive data
// - Write strobe asserted while SRAMs store data
// - Way pin gives hit way as address
// - Private select level programmable on cache hit
// - Way pins stable for whole cache access
// - Word select one cycle early: first word on hits and on slow-timing misses, later words in slow timing only
// - Ready in address, recovery, transfer data states
// - Fast 3/6 and slow 4/10 access timing
// - Read miss fills line before returning data
// - Fill request 16 bytes, 16-byte aligned
// - Fill writes SRAM starting at word zero
// - Bad fill reply invalidates whole directory
// - Bad fill reply raises bad access flag
// - Snooped foreign or own non-cacheable write invalidates
// - Replacement way toggles, reset to way 0
// - Hit needs tag match, tag valid, line valid
package cache_pkg;
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int WAYS = 2;
  localparam int SETS = 64;
  localparam int SET_W = 6;
  localparam int LINES = 8;
  localparam int LINE_W = 3;
  localparam int TAG_W = 19;
  localparam int WORD_LSB = 2;
  localparam int LINE_LSB = 4;
  localparam int SET_LSB = 7;
  localparam int TAG_LSB = 13;
  localparam int FIFO_DEPTH = 8;
  localparam logic [4:0] LINE_BYTES = 5'h10;
  localparam logic [3:0] LINE_ALIGN = 4'h0;
  localparam logic [1:0] WORDS_PER_LINE_M1 = 2'h3;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_DATA = 3'b001,
    ST_RECOVER = 3'b010,
    ST_MISS = 3'b011,
    ST_FILL = 3'b100
  } state_e;

  // Local bus access presented in its address state
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic write;
    logic cacheable;
    logic [1:0] words_m1;
  } lb_req_s;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic write;
    logic [4:0] len_bytes;
  } sb_req_s;

  typedef struct packed {
    logic rd_strobe;
    logic wr_strobe;
    logic way_hit;
    logic private_sel;
    logic [1:0] word;
  } sram_pins_s;
endpackage : cache_pkg

// >>> verilog/cache_sram_control.sv
// Purpose: Directory, SRAM strobes, ready and line fill for a cache.
// Assumes: lb_req_valid marks the address state of one access.
// Notes: Pins are open-drain; oe high pulls the pin low.
`timescale 1ns/1ns
module cache_sram_control #(
  parameter int DATA_W = cache_pkg::DATA_W,
  parameter int FIFO_DEPTH = cache_pkg::FIFO_DEPTH
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic cache_enable,
  input wire logic fast_timing,
  input wire logic private_hit_level,
  input wire logic lb_req_valid,
  input wire cache_pkg::lb_req_s lb_req,
  output logic lb_ready,
  output logic bad_access_flag,
  output logic busy,
  output logic [DATA_W-1:0] lb_fill_data,
  output logic lb_fill_drive,
  output logic sb_req_valid,
  output cache_pkg::sb_req_s sb_req,
  input wire logic sb_req_ready,
  input wire logic sb_fill_valid,
  input wire logic [DATA_W-1:0] sb_fill_data,
  input wire logic sb_fill_bad,
  output logic sb_fill_ready,
  input wire logic sb_snoop_valid,
  input wire logic [cache_pkg::ADDR_W-1:0] sb_snoop_addr,
  input wire logic sb_snoop_foreign,
  input wire logic sb_snoop_noncache,
  input wire cache_pkg::sram_pins_s sram_pin_in,
  output cache_pkg::sram_pins_s sram_pin_out,
  output cache_pkg::sram_pins_s sram_pin_oe
);
  // ==========================================================
  // Directory
  // ==========================================================
  logic [cache_pkg::TAG_W-1:0] tag_r [cache_pkg::WAYS][cache_pkg::SETS];
  logic tag_ok_r [cache_pkg::WAYS][cache_pkg::SETS];
  logic [cache_pkg::LINES-1:0] lval_r [cache_pkg::WAYS][cache_pkg::SETS];

  function automatic logic [cache_pkg::SET_W-1:0] set_of(
    input logic [cache_pkg::ADDR_W-1:0] a);
    return a[cache_pkg::SET_LSB +: cache_pkg::SET_W];
  endfunction : set_of

  function automatic logic [cache_pkg::LINE_W-1:0] line_of(
    input logic [cache_pkg::ADDR_W-1:0] a);
    return a[cache_pkg::LINE_LSB +: cache_pkg::LINE_W];
  endfunction : line_of

  // Returns {tag hit, line hit, way}
  function automatic logic [2:0] lookup(input logic [cache_pkg::ADDR_W-1:0] a);
    logic [2:0] r;
    r = 3'h0;
    for (int w = 0; w < cache_pkg::WAYS; w++) begin
      if (tag_ok_r[w][set_of(a)] &&
          tag_r[w][set_of(a)] == a[cache_pkg::TAG_LSB +: cache_pkg::TAG_W]) begin
        r = {1'b1, lval_r[w][set_of(a)][line_of(a)], w[0]};
      end
    end
    return r;
  endfunction : lookup

  logic [2:0] lk, snp;
  assign lk = lookup(lb_req.addr);
  assign snp = lookup(sb_snoop_addr);

  // ==========================================================
  // Fill buffer
  // ==========================================================
  logic fifo_out_valid, fifo_out_ready, fifo_bad;
  logic [DATA_W-1:0] fifo_data;

  fill_fifo #(
    .WIDTH(DATA_W + 1),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(core_clk),
    .rst_n(rst_n),
    .in_valid(sb_fill_valid),
    .in_ready(sb_fill_ready),
    .in_data({sb_fill_bad, sb_fill_data}),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data({fifo_bad, fifo_data})
  );

  // ==========================================================
  // Access sequencer
  // ==========================================================
  cache_pkg::state_e state_r, state_nxt;
  cache_pkg::lb_req_s req_r, req_nxt;
  logic [1:0] word_r, word_nxt, left_r, left_nxt;
  logic wait_r, wait_nxt, bad_r, bad_nxt, way_r, way_nxt;
  logic repl_r, repl_nxt, wt_pend_r, wt_pend_nxt;
  logic rd_stb, wr_stb, xfer, inv_loc, fill_upd, flush, new_block, bad_end;
  logic take, cache_now;

  assign take = lb_req_valid && !wt_pend_r && state_r == cache_pkg::ST_IDLE;
  assign cache_now = cache_enable && lb_req.cacheable;
  assign bad_end = bad_r | fifo_bad;

  always_comb begin
    state_nxt = state_r;
    req_nxt = req_r;
    word_nxt = word_r;
    left_nxt = left_r;
    wait_nxt = wait_r;
    bad_nxt = bad_r;
    way_nxt = way_r;
    repl_nxt = repl_r;
    wt_pend_nxt = wt_pend_r && !sb_req_ready;
    rd_stb = 1'b0;
    wr_stb = 1'b0;
    xfer = 1'b0;
    lb_ready = 1'b0;
    inv_loc = 1'b0;
    fill_upd = 1'b0;
    flush = 1'b0;
    new_block = 1'b0;
    fifo_out_ready = 1'b0;
    case (state_r)
      cache_pkg::ST_IDLE: begin
        if (take) begin
          req_nxt = lb_req;
          word_nxt = lb_req.addr[cache_pkg::WORD_LSB +: 2];
          left_nxt = lb_req.words_m1;
          wait_nxt = 1'b0;
          bad_nxt = 1'b0;
          if (cache_now) begin
            repl_nxt = !repl_r;
          end
          if (lb_req.write) begin
            if (!lb_req.cacheable && lk[1]) begin
              inv_loc = 1'b1;
            end else if (cache_now && lk[1]) begin
              lb_ready = 1'b1;
              way_nxt = lk[0];
              wt_pend_nxt = 1'b1;
              state_nxt = cache_pkg::ST_DATA;
            end
          end else if (cache_now) begin
            lb_ready = 1'b1;
            if (lk[1]) begin
              way_nxt = lk[0];
              state_nxt = cache_pkg::ST_DATA;
            end else begin
              // Reuse a way already holding the block, else the victim
              way_nxt = lk[2] ? lk[0] : repl_r;
              state_nxt = cache_pkg::ST_MISS;
            end
          end
        end
      end
      cache_pkg::ST_DATA: begin
        rd_stb = !req_r.write;
        wr_stb = req_r.write;
        // Slow timing spends one wait cycle before each transfer
        if (fast_timing || wait_r) begin
          xfer = 1'b1;
          lb_ready = 1'b1;
          wait_nxt = 1'b0;
          word_nxt = 2'(word_r + 2'h1);
          if (left_r == 2'h0) begin
            state_nxt = cache_pkg::ST_RECOVER;
          end else begin
            left_nxt = 2'(left_r - 2'h1);
          end
        end else begin
          wait_nxt = 1'b1;
        end
      end
      cache_pkg::ST_RECOVER: begin
        lb_ready = 1'b1;
        state_nxt = cache_pkg::ST_IDLE;
      end
      cache_pkg::ST_MISS: begin
        if (sb_req_ready) begin
          word_nxt = 2'h0;
          left_nxt = cache_pkg::WORDS_PER_LINE_M1;
          state_nxt = cache_pkg::ST_FILL;
        end
      end
      cache_pkg::ST_FILL: begin
        fifo_out_ready = 1'b1;
        if (fifo_out_valid) begin
          wr_stb = 1'b1;
          word_nxt = 2'(word_r + 2'h1);
          bad_nxt = bad_end;
          if (left_r == 2'h0) begin
            // Bad data stays in the SRAM line; directory forgets it all
            flush = bad_end;
            fill_upd = !bad_end;
            new_block = !lk_keep(req_r.addr, way_r);
            word_nxt = req_r.addr[cache_pkg::WORD_LSB +: 2];
            left_nxt = req_r.words_m1;
            wait_nxt = 1'b0;
            state_nxt = cache_pkg::ST_DATA;
          end else begin
            left_nxt = 2'(left_r - 2'h1);
          end
        end
      end
      default: begin
        state_nxt = cache_pkg::ST_IDLE;
      end
    endcase
    if (!cache_enable) begin
      repl_nxt = 1'b0;
    end
  end

  // True when the chosen way already holds this block's tag
  function automatic logic lk_keep(input logic [cache_pkg::ADDR_W-1:0] a,
                                   input logic w);
    return tag_ok_r[w][set_of(a)] &&
           tag_r[w][set_of(a)] == a[cache_pkg::TAG_LSB +: cache_pkg::TAG_W];
  endfunction : lk_keep

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= cache_pkg::ST_IDLE;
      req_r <= '0;
      word_r <= 2'h0;
      left_r <= 2'h0;
      wait_r <= 1'b0;
      bad_r <= 1'b0;
      way_r <= 1'b0;
      repl_r <= 1'b0;
      wt_pend_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      req_r <= req_nxt;
      word_r <= word_nxt;
      left_r <= left_nxt;
      wait_r <= wait_nxt;
      bad_r <= bad_nxt;
      way_r <= way_nxt;
      repl_r <= repl_nxt;
      wt_pend_r <= wt_pend_nxt;
    end
  end

  // ==========================================================
  // Directory update
  // ==========================================================
  logic snp_inv;
  assign snp_inv = sb_snoop_valid && (sb_snoop_foreign || sb_snoop_noncache) && snp[1];

  // Snoop is applied last, but it looks up the old directory, so a write racing a fill does not kill the line
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int w = 0; w < cache_pkg::WAYS; w++) begin
        for (int s = 0; s < cache_pkg::SETS; s++) begin
          tag_ok_r[w][s] <= 1'b0;
          lval_r[w][s] <= '0;
        end
      end
    end else if (flush) begin
      for (int w = 0; w < cache_pkg::WAYS; w++) begin
        for (int s = 0; s < cache_pkg::SETS; s++) begin
          tag_ok_r[w][s] <= 1'b0;
          lval_r[w][s] <= '0;
        end
      end
    end else begin
      if (fill_upd) begin
        tag_ok_r[way_r][set_of(req_r.addr)] <= 1'b1;
        if (new_block) begin
          lval_r[way_r][set_of(req_r.addr)] <= '0;
        end
        lval_r[way_r][set_of(req_r.addr)][line_of(req_r.addr)] <= 1'b1;
      end
      if (inv_loc) begin
        lval_r[lk[0]][set_of(lb_req.addr)][line_of(lb_req.addr)] <= 1'b0;
      end
      if (snp_inv) begin
        lval_r[snp[0]][set_of(sb_snoop_addr)][line_of(sb_snoop_addr)] <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (fill_upd) begin
      tag_r[way_r][set_of(req_r.addr)] <=
        req_r.addr[cache_pkg::TAG_LSB +: cache_pkg::TAG_W];
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  cache_pkg::sram_pins_s act;
  logic miss_req;

  assign miss_req = state_r == cache_pkg::ST_MISS;
  assign sb_req_valid = miss_req || wt_pend_r;
  // Idle is blocked while a write-through waits, so the two never overlap
  always_comb begin
    if (miss_req) begin
      sb_req.addr = {req_r.addr[cache_pkg::ADDR_W-1:cache_pkg::LINE_LSB],
                     cache_pkg::LINE_ALIGN};
      sb_req.write = 1'b0;
      sb_req.len_bytes = cache_pkg::LINE_BYTES;
    end else begin
      sb_req.addr = req_r.addr;
      sb_req.write = 1'b1;
      sb_req.len_bytes = 5'({3'h0, req_r.words_m1} + 5'h1) << 2;
    end
  end

  assign bad_access_flag = xfer && bad_r;
  assign busy = (state_r != cache_pkg::ST_IDLE) || wt_pend_r;
  assign lb_fill_data = fifo_data;
  assign lb_fill_drive = state_r == cache_pkg::ST_FILL && fifo_out_valid;

  always_comb begin
    act.rd_strobe = rd_stb;
    act.wr_strobe = wr_stb;
    act.way_hit = !way_r;
    act.private_sel = !private_hit_level;
    // Address state shows the first word a cycle before its transfer; later words show word_r
    act.word = (state_r == cache_pkg::ST_IDLE) ?
               ~lb_req.addr[cache_pkg::WORD_LSB +: 2] : ~word_r;
  end

  assign sram_pin_oe = act;
  assign sram_pin_out = '0;
endmodule : cache_sram_control

// >>> verilog/fill_fifo.sv
// Purpose: Synchronous FIFO carrying fill words toward the SRAMs.
// Assumes: Single clock, DEPTH a power of two.
// Notes: Full and empty come from the occupancy count.
`timescale 1ns/1ns
module fill_fifo #(
  parameter int WIDTH = 33,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
  logic [PW:0] cnt_r, cnt_nxt;
  logic push, pop;

  assign in_ready = (cnt_r != (PW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data = mem[rd_r];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_comb begin
    wr_nxt = push ? PW'(wr_r + 1'b1) : wr_r;
    rd_nxt = pop ? PW'(rd_r + 1'b1) : rd_r;
    cnt_nxt = cnt_r;
    if (push && !pop) begin
      cnt_nxt = (PW+1)'(cnt_r + 1'b1);
    end else if (pop && !push) begin
      cnt_nxt = (PW+1)'(cnt_r - 1'b1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
    end else begin
      wr_r <= wr_nxt;
      rd_r <= rd_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_r] <= in_data;
    end
  end
endmodule : fill_fifo
